// ==== hw/hbis_top.sv ====
// Hub interrupt pin, strap latching and standby reset with Wishbone registers
//
// Functional notes
// - Mode bit picks general or suspend interrupt
// - General mode: enabled status update pulls low
// - Clearing status register releases line high
// - Suspend mode: low when unconfigured or suspended
// - Suspend mode: high only configured and active
// - Upper strap picks stored slave address register
// - Lower strap gives slave address LSB
// - Reference straps latched in init, frequency derived
// - Active-low reset pin holds standby
// - Codes 00/01/10/11 mean 38.4/26/19.2/12 MHz
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module hbis_top
    import hbis_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Wishbone classic slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [hbis_pkg::WB_AW-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // Device pins
    input  wire logic                      reset_n_i,
    input  wire logic [1:0]                slave_addr_strap_i,
    input  wire logic [1:0]                ref_sel_strap_i,
    input  wire logic                      int_n_in_i,
    output logic                           int_n_out_o,
    output logic                           int_n_oe_o,
    // Hub core side, same clock
    input  wire logic [hbis_pkg::EVT_W-1:0] status_update_i,
    input  wire logic                      hub_configured_i,
    input  wire logic                      hub_suspended_i,
    output logic [hbis_pkg::SADDR_W-1:0]   slave_addr_o,
    output logic [hbis_pkg::KHZ_W-1:0]     ref_khz_o,
    output logic                           standby_o,
    output logic                           irq_o
);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic       reset_n_s;
    logic [1:0] asel_s;
    logic [1:0] rsel_s;

    // Sync reset for the reset pin itself, so it can be sampled
    // even while the rest of the block is held
    hbis_sync #(.W(1)) u_sync_rst (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (reset_n_i),
        .sync_o  (reset_n_s)
    );

    hbis_sync #(.W(4)) u_sync_straps (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({slave_addr_strap_i, ref_sel_strap_i}),
        .sync_o  ({asel_s, rsel_s})
    );

    // The line level is only informational for a driver-side block
    logic       int_line_unused;
    assign int_line_unused = int_n_in_i;

    // Core reset: bus reset or reset pin in standby
    logic core_rst;
    assign core_rst = rst_i | ~reset_n_s;

    // ********************************************************
    // Hub stage sequencing
    // ********************************************************
    hbis_stage_e               stage_q;
    hbis_stage_e               stage_d;
    logic [INIT_CNT_W-1:0]     init_cnt_q;
    logic                      init_done;
    logic                      in_run;
    logic [1:0]                asel_q;
    logic [1:0]                rsel_q;

    assign init_done = (init_cnt_q == INIT_CNT_W'(INIT_CYCLES - 1));
    assign in_run    = (stage_q == HBIS_RUN);

    always_comb
    begin
        stage_d = stage_q;
        unique case (stage_q)
            HBIS_STANDBY: stage_d = HBIS_INIT;
            HBIS_INIT:    stage_d = init_done ? HBIS_RUN : HBIS_INIT;
            HBIS_RUN:     stage_d = HBIS_RUN;
            default:      stage_d = HBIS_STANDBY;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (core_rst)
        begin
            stage_q    <= HBIS_STANDBY;
            init_cnt_q <= '0;
        end
        else
        begin
            stage_q    <= stage_d;
            init_cnt_q <= (stage_q == HBIS_INIT && !init_done) ? init_cnt_q + 1'b1 : init_cnt_q;
        end
    end

    // Straps caught at the end of init and frozen afterwards;
    // the synchronisers have filled by then
    always_ff @(posedge clk_i)
    begin
        if (core_rst)
        begin
            asel_q <= 2'h0;
            rsel_q <= 2'h0;
        end
        else if (stage_q == HBIS_INIT && init_done)
        begin
            asel_q <= asel_s;
            rsel_q <= rsel_s;
        end
    end

    // ********************************************************
    // Wishbone decode
    // ********************************************************
    logic        wb_req;
    logic        wb_wr;
    logic        wb_rd;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_mask;
    logic        hit_adra;
    logic        hit_adrb;
    logic        hit_hub;

    assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr    = wb_req & wb_we_i;
    assign wb_rd    = wb_req & ~wb_we_i;
    assign hit_ctrl = (wb_adr_i == REG_CTRL);
    assign hit_stat = (wb_adr_i == REG_IRQ_STATUS);
    assign hit_mask = (wb_adr_i == REG_IRQ_MASK);
    assign hit_adra = (wb_adr_i == REG_ADDR_A);
    assign hit_adrb = (wb_adr_i == REG_ADDR_B);
    assign hit_hub  = (wb_adr_i == REG_HUB_STATE);

    // ********************************************************
    // Registers
    // ********************************************************
    logic                 susp_sel_q;
    logic [EVT_W-1:0]     status_q;
    logic [EVT_W-1:0]     status_d;
    logic [EVT_W-1:0]     mask_q;
    logic [SADDR_W-1:0]   addr_a_q;
    logic [SADDR_W-1:0]   addr_b_q;
    logic [EVT_W-1:0]     status_clr;
    logic [31:0]          hub_state;
    logic [31:0]          rd_mux;

    // Read clears all bits; a write of ones clears those bits.
    // A fresh event in the same cycle survives the clear.
    assign status_clr = (wb_rd && hit_stat) ? {EVT_W{1'b1}} :
                        (wb_wr && hit_stat && wb_sel_i[0]) ? wb_dat_i[EVT_W-1:0] : '0;
    assign status_d   = (status_q & ~status_clr) | status_update_i;

    always_ff @(posedge clk_i)
    begin
        if (core_rst)
            status_q <= '0;
        else
            status_q <= status_d;
    end

    always_ff @(posedge clk_i)
    begin
        if (core_rst)
        begin
            susp_sel_q <= CTRL_RST;
            mask_q     <= IRQ_MASK_RST;
            addr_a_q   <= ADDR_A_RST;
            addr_b_q   <= ADDR_B_RST;
        end
        else if (wb_wr && wb_sel_i[0])
        begin
            if (hit_ctrl)
                susp_sel_q <= wb_dat_i[CTRL_SUSP_SEL];
            if (hit_mask)
                mask_q <= wb_dat_i[EVT_W-1:0];
            if (hit_adra)
                addr_a_q <= wb_dat_i[SADDR_W-1:0];
            if (hit_adrb)
                addr_b_q <= wb_dat_i[SADDR_W-1:0];
        end
    end

    assign hub_state = {ref_khz_o, 1'b0, stage_q, rsel_q, asel_q, 1'b0, slave_addr_o};

    assign rd_mux = hit_ctrl ? {31'h0, susp_sel_q} :
                    hit_stat ? {24'h0, status_q} :
                    hit_mask ? {24'h0, mask_q} :
                    hit_adra ? {25'h0, addr_a_q} :
                    hit_adrb ? {25'h0, addr_b_q} :
                    hit_hub  ? hub_state : 32'h0;

    // One wait state: ack the cycle after the request is seen,
    // unmapped addresses answer with zero data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_rd ? rd_mux : 32'h0;
        end
    end

    // ********************************************************
    // Derived outputs
    // ********************************************************
    logic [SADDR_W-1:0] addr_pick;
    logic               pending;
    logic               hub_active;
    logic               int_low_d;

    assign addr_pick  = {(asel_q[1] ? addr_b_q[SADDR_W-1:1] : addr_a_q[SADDR_W-1:1]), asel_q[0]};
    assign pending    = |(status_q & mask_q);
    assign hub_active = hub_configured_i & ~hub_suspended_i;
    assign int_low_d  = susp_sel_q ? ~hub_active : pending;

    always_ff @(posedge clk_i)
    begin
        if (core_rst)
        begin
            int_n_oe_o   <= 1'b0;
            int_n_out_o  <= 1'b0;
            irq_o        <= 1'b0;
            slave_addr_o <= '0;
            ref_khz_o    <= '0;
        end
        else
        begin
            int_n_oe_o   <= int_low_d;
            int_n_out_o  <= 1'b0;
            irq_o        <= pending;
            slave_addr_o <= in_run ? addr_pick : '0;
            ref_khz_o    <= in_run ? hbis_ref_khz(rsel_q) : '0;
        end
    end

    // Standby flag follows the pin and is reset by rst_i alone, so it tracks while the pin holds core reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            standby_o <= 1'b1;
        else
            standby_o <= ~reset_n_s;
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !reset_n_s);

    sequence s_standby;
        stage_q == HBIS_STANDBY;
    endsequence

    sequence s_leave;
        stage_q != HBIS_STANDBY;
    endsequence

    sequence s_settled;
        in_run ##1 in_run;
    endsequence

    property p_gen_low;
        (!susp_sel_q && pending) |=> int_n_oe_o;
    endproperty
    a_gen_low: assert property (p_gen_low) else $error("general irq not pulled low");

    property p_gen_release;
        (!susp_sel_q && !pending) |=> !int_n_oe_o;
    endproperty
    a_gen_release: assert property (p_gen_release) else $error("general irq not released");

    property p_rd_clear;
        (wb_rd && hit_stat && status_update_i == '0) |=> (status_q == '0);
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("status read did not clear");

    property p_susp_low;
        (susp_sel_q && !hub_active) |=> int_n_oe_o;
    endproperty
    a_susp_low: assert property (p_susp_low) else $error("suspend irq not low");

    property p_susp_high;
        (susp_sel_q && hub_active) |=> !int_n_oe_o;
    endproperty
    a_susp_high: assert property (p_susp_high) else $error("suspend irq not high");

    property p_open_drain;
        !int_n_out_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("interrupt driven high");

    property p_addr;
        s_settled |-> slave_addr_o == {($past(asel_q[1]) ? $past(addr_b_q[6:1]) : $past(addr_a_q[6:1])), asel_q[0]};
    endproperty
    a_addr: assert property (p_addr) else $error("slave address wrong");

    property p_strap_hold;
        s_settled |-> ($stable(asel_q) && $stable(rsel_q));
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("straps changed after init");

    property p_ref;
        s_settled |-> ref_khz_o == hbis_ref_khz(rsel_q);
    endproperty
    a_ref: assert property (p_ref) else $error("reference frequency wrong");

    property p_init_first;
        s_standby ##1 s_leave |-> stage_q == HBIS_INIT;
    endproperty
    a_init_first: assert property (p_init_first) else $error("init stage skipped");

    // Init length counted apart from the stage counter, so a broken counter shows
    logic [INIT_CNT_W-1:0] init_seen_q;

    always_ff @(posedge clk_i)
    begin
        if (core_rst || stage_q != HBIS_INIT)
            init_seen_q <= '0;
        else
            init_seen_q <= init_seen_q + 1'b1;
    end

    property p_init_len;
        $rose(in_run) |-> (init_seen_q == INIT_CNT_W'(INIT_CYCLES));
    endproperty
    a_init_len: assert property (p_init_len) else $error("init stage length wrong");

    property p_init_bound;
        (stage_q == HBIS_INIT) |-> (init_seen_q < INIT_CNT_W'(INIT_CYCLES));
    endproperty
    a_init_bound: assert property (p_init_bound) else $error("init stage overran");

endmodule : hbis_top

// ==== hw/hbis_pkg.sv ====
// Package of constants for the hub interrupt and strap pin block
package hbis_pkg;

    // ********************************************************
    // Clock and timing
    // ********************************************************
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
    // Init stage lasts at least this long after reset release
    localparam int unsigned INIT_TIME_NS    = 200;
    localparam int unsigned INIT_CYCLES     = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned INIT_CNT_W      = 4;

    // ********************************************************
    // Wishbone register map (byte addresses)
    // ********************************************************
    localparam int unsigned WB_AW           = 8;
    localparam logic [7:0]  REG_CTRL        = 8'h00;
    localparam logic [7:0]  REG_IRQ_STATUS  = 8'h04;
    localparam logic [7:0]  REG_IRQ_MASK    = 8'h08;
    localparam logic [7:0]  REG_ADDR_A      = 8'h0C;
    localparam logic [7:0]  REG_ADDR_B      = 8'h10;
    localparam logic [7:0]  REG_HUB_STATE   = 8'h14;

    // ********************************************************
    // Fields and reset values
    // ********************************************************
    localparam int unsigned EVT_W           = 8;
    localparam int unsigned SADDR_W         = 7;
    localparam int unsigned CTRL_SUSP_SEL   = 0;
    localparam logic        CTRL_RST        = 1'b0;
    localparam logic [7:0]  IRQ_MASK_RST    = 8'h00;
    // Default slave addresses, arbitrary plain values
    localparam logic [6:0]  ADDR_A_RST      = 7'h10;
    localparam logic [6:0]  ADDR_B_RST      = 7'h20;
    // HUB_STATE layout
    localparam int unsigned HS_ADDR_LSB     = 0;
    localparam int unsigned HS_ASEL_LSB     = 8;
    localparam int unsigned HS_REF_LSB      = 10;
    localparam int unsigned HS_STATE_LSB    = 12;
    localparam int unsigned HS_KHZ_LSB      = 16;

    // ********************************************************
    // Reference clock select decode, in kHz
    // ********************************************************
    localparam int unsigned KHZ_W           = 16;
    localparam logic [1:0]  REF_SEL_38M4    = 2'h0;
    localparam logic [1:0]  REF_SEL_26M0    = 2'h1;
    localparam logic [1:0]  REF_SEL_19M2    = 2'h2;
    localparam logic [1:0]  REF_SEL_12M0    = 2'h3;
    localparam logic [15:0] KHZ_38M4        = 16'h9600;
    localparam logic [15:0] KHZ_26M0        = 16'h6590;
    localparam logic [15:0] KHZ_19M2        = 16'h4B00;
    localparam logic [15:0] KHZ_12M0        = 16'h2EE0;

    // ********************************************************
    // Hub power-up stages
    // ********************************************************
    typedef enum logic [2:0] {
        HBIS_STANDBY = 3'b001,
        HBIS_INIT    = 3'b010,
        HBIS_RUN     = 3'b100
    } hbis_stage_e;

    function automatic logic [15:0] hbis_ref_khz(input logic [1:0] code);
        logic [15:0] khz;
        khz = KHZ_12M0;
        unique case (code)
            REF_SEL_38M4: khz = KHZ_38M4;
            REF_SEL_26M0: khz = KHZ_26M0;
            REF_SEL_19M2: khz = KHZ_19M2;
            REF_SEL_12M0: khz = KHZ_12M0;
        endcase
        return khz;
    endfunction : hbis_ref_khz

endpackage : hbis_pkg

// ==== hw/hbis_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module hbis_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : hbis_sync

// ==== dv/hbis_far_end.sv ====
// Model of the board and system processor around the interrupt, reset and strap pins
`timescale 1ns/1ps
module hbis_far_end (
    input  wire logic       clk_i,
    input  wire logic       hold_rst_i,
    input  wire logic [1:0] asel_i,
    input  wire logic [1:0] rsel_i,
    input  wire logic       int_n_oe_i,
    output logic            reset_n_o,
    output logic [1:0]      slave_addr_strap_o,
    output logic [1:0]      ref_sel_strap_o,
    output logic            int_line_o
);
    // Board pull-up: the wire is only ever low when the device pulls it
    assign int_line_o         = int_n_oe_i ? 1'b0 : 1'b1;
    assign slave_addr_strap_o = asel_i;
    // Straps follow the reference frequency that the bench claims to apply
    assign ref_sel_strap_o    = rsel_i;
    always_ff @(posedge clk_i)
    begin
        reset_n_o <= !hold_rst_i;
    end
endmodule : hbis_far_end

// ==== dv/hbis_top_tb.sv ====
// Self-checking bench for the hub interrupt and strap pin block
`timescale 1ns/1ps
module hbis_top_tb;
    import hbis_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, hold_rst = 1'b1;
    logic [7:0]  adr = 8'h00, upd = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, wb_dat_o;
    logic [1:0]  asel = 2'h0, rsel = 2'h0, asel_p, rsel_p;
    logic        cfg = 1'b0, susp = 1'b0, wb_ack_o, reset_n, line, int_n_out_o, int_n_oe_o;
    logic        standby_o, irq_o;
    logic [6:0]  slave_addr_o;
    logic [15:0] ref_khz_o;
    int          failures = 0, samples_checked = 0, cycles = 0;

    always #10 clk_i = ~clk_i;

    hbis_far_end far (.clk_i(clk_i), .hold_rst_i(hold_rst), .asel_i(asel), .rsel_i(rsel),
        .int_n_oe_i(int_n_oe_o), .reset_n_o(reset_n), .slave_addr_strap_o(asel_p),
        .ref_sel_strap_o(rsel_p), .int_line_o(line));

    hbis_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .reset_n_i(reset_n), .slave_addr_strap_i(asel_p), .ref_sel_strap_i(rsel_p),
        .int_n_in_i(line), .int_n_out_o(int_n_out_o), .int_n_oe_o(int_n_oe_o),
        .status_update_i(upd), .hub_configured_i(cfg), .hub_suspended_i(susp),
        .slave_addr_o(slave_addr_o), .ref_khz_o(ref_khz_o), .standby_o(standby_o), .irq_o(irq_o));

    // ********************************************************
    // Shared tasks
    // ********************************************************
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One classic cycle; the slave's ack is the only thing that ends the wait
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb_xfer

    task automatic pulse(input logic [7:0] m);
        @(posedge clk_i);
        upd <= m;
        @(posedge clk_i);
        upd <= 8'h00;
        repeat (3) @(posedge clk_i);
    endtask : pulse

    // Pin level, drive value and drive enable together
    task automatic pin(input logic low);
        repeat (3) @(posedge clk_i);
        check("int_n_oe_o", low, int_n_oe_o);
        check("int line", !low, line);
        check("int_n_out_o", 1'b0, int_n_out_o);
    endtask : pin

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_straps;
        logic [31:0] q;
        logic [1:0]  c;
        logic [15:0] khz [4];
        khz = '{16'h9600, 16'h6590, 16'h4B00, 16'h2EE0};
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i);
            asel <= c;
            rsel <= c;
            hold_rst <= 1'b1;
            repeat (6) @(posedge clk_i);
            check("standby_o", 1'b1, standby_o);
            check("ref_khz_o in standby", 16'h0, ref_khz_o);
            hold_rst <= 1'b0;
            repeat (30) @(posedge clk_i);
            // Moving the straps after init must change nothing
            asel <= ~c;
            rsel <= ~c;
            repeat (6) @(posedge clk_i);
            check("standby_o", 1'b0, standby_o);
            check("slave_addr_o", {c[1] ? 6'h10 : 6'h08, c[0]}, slave_addr_o);
            check("ref_khz_o", khz[i], ref_khz_o);
            wb_xfer(1'b0, REG_HUB_STATE, 32'h0, q);
            check("stage", 3'h4, q[14:12]);
            check("latched straps", {c, c}, q[11:8]);
        end
        $display("test straps done");
    endtask : t_straps

    task automatic t_general;
        logic [31:0] q;
        wb_xfer(1'b1, REG_CTRL, 32'h0, q);
        wb_xfer(1'b1, REG_IRQ_MASK, 32'h5, q);
        wb_xfer(1'b0, REG_IRQ_MASK, 32'h0, q);
        check("irq mask", 32'h5, q);
        pin(1'b0);
        pulse(8'h04);
        pin(1'b1);
        check("irq_o", 1'b1, irq_o);
        wb_xfer(1'b0, REG_IRQ_STATUS, 32'h0, q);
        check("status read", 32'h4, q);
        pin(1'b0);
        pulse(8'h02);
        pin(1'b0);
        check("irq_o masked", 1'b0, irq_o);
        pulse(8'h01);
        pin(1'b1);
        wb_xfer(1'b1, REG_IRQ_STATUS, 32'h1, q);
        pin(1'b0);
        wb_xfer(1'b0, REG_IRQ_STATUS, 32'h0, q);
        check("masked bit sticky", 32'h2, q);
        wb_xfer(1'b0, 8'h3C, 32'h0, q);
        check("unmapped read", 32'h0, q);
        $display("test general interrupt done");
    endtask : t_general

    task automatic t_suspend;
        logic [31:0] q;
        pulse(8'h01);
        wb_xfer(1'b1, REG_CTRL, 32'h1, q);
        for (int i = 0; i < 4; i++)
        begin
            cfg  <= i[1];
            susp <= i[0];
            pin(!(i[1] && !i[0]));
        end
        wb_xfer(1'b1, REG_CTRL, 32'h0, q);
        pin(1'b1);
        wb_xfer(1'b0, REG_IRQ_STATUS, 32'h0, q);
        pin(1'b0);
        $display("test suspend interrupt done");
    endtask : t_suspend

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            $display("[FAIL] timeout expected done seen hang");
            close_out();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_straps();
        t_general();
        t_suspend();
        close_out();
    end
endmodule : hbis_top_tb
